/* addressing_mode_ea_unit.sv */
// Overview of operation
// - Taken branch adds sign-extended last byte to PC; else falls through.
// - Relative branch span covers -128 to +127 from next opcode.
// - Pointer-only address is the index register, zero page, one byte.
// - Pointer-plus-byte address is index plus unsigned byte, up to 510.
// - Pointer-plus-word address is index plus unsigned 16-bit word.
// - Bit modify: opcode picks bit, next byte is zero-page address.
// - Bit branch: opcode bit and state, direct byte, signed offset byte.
// - Bit branch span is -128 to +127 from next opcode.
// - Bit branch copies the tested bit into carry, taken or not.
// - Implied-operand instructions are one byte, all in the opcode.
// - Direct address is the single byte after the opcode, zero page.
`timescale 1ns/10ps
module addressing_mode_ea_unit (
   input  wire logic          clk,       // Core clock, 40 MHz
   input  wire logic          rst_b,     // Asynchronous reset, active low
   input  wire logic          start,     // Decode request pulse
   input  wire logic [7:0]    opcode,    // Opcode byte
   input  wire logic [15:0]   op_pc,     // Address of the opcode
   input  wire logic [7:0]    index_val, // Index register
   input  wire logic          cond_ok,   // Branch condition holds
   input  wire logic [7:0]    mem_rdata, // Memory read data
   input  wire logic          mem_valid, // Memory read data valid
   output ea_pkg::mode_t      mode,      // Decoded mode
   output logic [15:0]        mem_addr,  // Memory read address
   output logic               mem_rd,    // Memory read strobe
   output logic               busy,      // Decode in progress
   output logic               done,      // Result ready pulse
   output logic [15:0]        ea,        // Effective address
   output logic               ea_valid,  // Effective address meaningful
   output logic [15:0]        next_pc,   // Following program counter
   output logic               taken,     // Branch taken
   output logic               carry,     // New carry value
   output logic               carry_we,  // Carry write pulse
   output logic [2:0]         bit_sel,   // Selected bit number
   output logic               bit_set    // Set, or wanted state
);
   ea_pkg::core_t s;
   ea_pkg::core_t next_s;
   ea_pkg::mode_t m_in;

   // Mode of the incoming opcode
   assign m_in = ea_pkg::mode_of(opcode);

   // Next state of the whole unit
   always_comb begin
      next_s = s;
      next_s.mem_rd = 1'b0;
      next_s.done = 1'b0;
      next_s.carry_we = 1'b0;
      case (s.st)
         ea_pkg::st_idle: begin
            if (start) begin
               next_s.mode = m_in;
               next_s.len = ea_pkg::len_of(m_in);
               next_s.idx = ea_pkg::LEN_ONE;
               next_s.opnd = 1'b0;
               next_s.opc = opcode;
               next_s.pc = op_pc;
               next_s.ixr = index_val;
               next_s.cond = cond_ok;
               next_s.busy = 1'b1;
               next_s.ea_valid = 1'b0;
               next_s.taken = 1'b0;
               if (ea_pkg::len_of(m_in) == ea_pkg::LEN_ONE) begin
                  next_s.st = ea_pkg::st_calc;
               end else begin
                  next_s.mem_rd = 1'b1;
                  next_s.mem_addr = ea_pkg::zext_add(op_pc, 8'h01);
                  next_s.st = ea_pkg::st_wait;
               end
            end
         end
         ea_pkg::st_wait: begin
            if (mem_valid) begin
               if (s.opnd) begin
                  next_s.tbit = mem_rdata[s.bit_sel];
                  next_s.st = ea_pkg::st_calc;
               end else begin
                  if (s.idx == ea_pkg::LEN_ONE) begin
                     next_s.b1 = mem_rdata;
                  end else begin
                     next_s.b2 = mem_rdata;
                  end
                  if (s.idx < s.len - 2'h1) begin
                     next_s.idx = s.idx + 2'h1;
                     next_s.mem_rd = 1'b1;
                     next_s.mem_addr = ea_pkg::zext_add(s.pc, {6'h00, s.idx + 2'h1});
                  end else if (s.mode == ea_pkg::bit_branch_mode) begin
                     next_s.opnd = 1'b1;
                     next_s.bit_sel = s.opc[3:1];
                     next_s.mem_rd = 1'b1;
                     next_s.mem_addr = {ea_pkg::PAGE_ZERO, s.b1};
                  end else begin
                     next_s.st = ea_pkg::st_calc;
                  end
               end
            end
         end
         ea_pkg::st_calc: begin
            next_s.st = ea_pkg::st_idle;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.ea_valid = 1'b1;
            next_s.ea = ea_pkg::RST_ADDR;
            next_s.next_pc = ea_pkg::zext_add(s.pc, {6'h00, s.len});
            next_s.bit_sel = s.opc[3:1];
            next_s.bit_set = ~s.opc[0];
            case (s.mode)
               ea_pkg::literal_operand_mode: begin
                  next_s.ea = ea_pkg::zext_add(s.pc, 8'h01);
               end
               ea_pkg::direct_address_mode: begin
                  next_s.ea = {ea_pkg::PAGE_ZERO, s.b1};
               end
               ea_pkg::long_address_mode: begin
                  next_s.ea = {s.b1, s.b2};
               end
               ea_pkg::pointer_only_mode: begin
                  next_s.ea = {ea_pkg::PAGE_ZERO, s.ixr};
               end
               ea_pkg::pointer_plus_byte_mode: begin
                  next_s.ea = ea_pkg::zext_add({ea_pkg::PAGE_ZERO, s.b1}, s.ixr);
               end
               ea_pkg::pointer_plus_word_mode: begin
                  next_s.ea = ea_pkg::zext_add({s.b1, s.b2}, s.ixr);
               end
               ea_pkg::bit_modify_mode: begin
                  next_s.ea = {ea_pkg::PAGE_ZERO, s.b1};
               end
               ea_pkg::branch_offset_mode: begin
                  next_s.ea_valid = 1'b0;
                  next_s.taken = s.cond;
                  if (s.cond) begin
                     next_s.next_pc = ea_pkg::rel_add(next_s.next_pc, s.b1);
                  end
               end
               ea_pkg::bit_branch_mode: begin
                  next_s.ea = {ea_pkg::PAGE_ZERO, s.b1};
                  next_s.carry = s.tbit;
                  next_s.carry_we = 1'b1;
                  next_s.taken = (s.tbit == ~s.opc[0]);
                  if (s.tbit == ~s.opc[0]) begin
                     next_s.next_pc = ea_pkg::rel_add(next_s.next_pc, s.b2);
                  end
               end
               default: begin
                  next_s.ea_valid = 1'b0;
               end
            endcase
         end
         default: begin
            next_s.st = ea_pkg::st_idle;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign mode = s.mode;
   assign mem_addr = s.mem_addr;
   assign mem_rd = s.mem_rd;
   assign busy = s.busy;
   assign done = s.done;
   assign ea = s.ea;
   assign ea_valid = s.ea_valid;
   assign next_pc = s.next_pc;
   assign taken = s.taken;
   assign carry = s.carry;
   assign carry_we = s.carry_we;
   assign bit_sel = s.bit_sel;
   assign bit_set = s.bit_set;

   // Checks on the decoded results and on the operand reads
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_ix_zero_page: assert property (
      done && mode == ea_pkg::pointer_only_mode |->
      ea[15:8] == 8'h00 && next_pc == s.pc + 16'h0001)
      else $error("pointer-only address outside zero page");

   a_ix1_sum: assert property (
      done && mode == ea_pkg::pointer_plus_byte_mode |->
      ea == {8'h00, s.b1} + {8'h00, s.ixr} && ea <= 16'h01fe)
      else $error("pointer-plus-byte address wrong");

   a_ix2_sum: assert property (
      done && mode == ea_pkg::pointer_plus_word_mode |->
      ea == {s.b1, s.b2} + {8'h00, s.ixr} && next_pc == s.pc + 16'h0003)
      else $error("pointer-plus-word address wrong");

   a_rel_fall: assert property (
      done && mode == ea_pkg::branch_offset_mode && !taken |->
      next_pc == s.pc + 16'h0002)
      else $error("untaken branch moved the counter");

   a_rel_span: assert property (
      done && mode == ea_pkg::branch_offset_mode && taken |->
      $signed(next_pc - s.pc - 16'h0002) >= -128 &&
      $signed(next_pc - s.pc - 16'h0002) <= 127)
      else $error("relative target out of span");

   a_btb_carry: assert property (
      s.st == ea_pkg::st_wait && s.opnd && mem_valid |->
      ##2 carry_we && (($past(mem_rdata, 2) >> bit_sel) & 8'h01) == {7'h00, carry})
      else $error("carry not copied from tested bit");

   a_btb_taken: assert property (
      done && mode == ea_pkg::bit_branch_mode |->
      taken == (carry == ~s.opc[0]) && ea == {8'h00, s.b1})
      else $error("bit branch decision wrong");

   a_btb_target: assert property (
      done && mode == ea_pkg::bit_branch_mode && taken |->
      next_pc == s.pc + 16'h0003 + {{8{s.b2[7]}}, s.b2})
      else $error("bit branch target wrong");

   a_bsc_page: assert property (
      done && mode == ea_pkg::bit_modify_mode |->
      ea[15:8] == 8'h00 && bit_sel == s.opc[3:1] && next_pc == s.pc + 16'h0002)
      else $error("bit modify decode wrong");

   a_inh_short: assert property (
      start && !busy && ea_pkg::mode_of(opcode) == ea_pkg::implied_operand_mode |->
      ##2 done && !ea_valid && next_pc == $past(op_pc, 2) + 16'h0001)
      else $error("implied instruction not one byte");

   a_fetch_next: assert property (
      start && !busy && ea_pkg::mode_of(opcode) != ea_pkg::implied_operand_mode &&
      ea_pkg::mode_of(opcode) != ea_pkg::pointer_only_mode |=>
      mem_rd && mem_addr == $past(op_pc) + 16'h0001)
      else $error("operand fetch address wrong");

   a_ix_timing: assert property (
      start && !busy && ea_pkg::mode_of(opcode) == ea_pkg::pointer_only_mode |->
      ##2 done && ea_valid && ea == {8'h00, $past(index_val, 2)})
      else $error("pointer-only address or timing wrong");

   a_ix1_len: assert property (
      done && mode == ea_pkg::pointer_plus_byte_mode |->
      next_pc == s.pc + 16'h0002 && ea_valid)
      else $error("pointer-plus-byte length wrong");

   a_ix2_carry: assert property (
      done && mode == ea_pkg::pointer_plus_word_mode &&
      ({1'b0, s.b2} + {1'b0, s.ixr}) > 9'h0ff |->
      ea[15:8] == s.b1 + 8'h01)
      else $error("index carry lost in upper byte");

   a_rel_target: assert property (
      done && mode == ea_pkg::branch_offset_mode && taken |->
      next_pc == s.pc + 16'h0002 + {{8{s.b1[7]}}, s.b1} && !ea_valid)
      else $error("relative branch target wrong");

   a_rel_cond: assert property (
      done && mode == ea_pkg::branch_offset_mode |->
      taken == s.cond)
      else $error("relative branch decision wrong");

   a_btb_fall: assert property (
      done && mode == ea_pkg::bit_branch_mode && !taken |->
      next_pc == s.pc + 16'h0003)
      else $error("untaken bit branch moved the counter");

   a_inh_noread: assert property (
      busy && mode == ea_pkg::implied_operand_mode |->
      !mem_rd)
      else $error("implied instruction read memory");

   a_dir_page: assert property (
      done && mode == ea_pkg::direct_address_mode |->
      ea == {8'h00, s.b1} && next_pc == s.pc + 16'h0002)
      else $error("direct address wrong");

   // carry written only by bit branch
   a_carry_only: assert property (
      carry_we |->
      done && mode == ea_pkg::bit_branch_mode)
      else $error("carry written outside bit branch");
endmodule : addressing_mode_ea_unit

/* ea_pkg.sv */
package ea_pkg;
   // Address and data widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Values after reset
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;

   // Instruction lengths in bytes
   localparam logic [1:0] LEN_ONE   = 2'h1;
   localparam logic [1:0] LEN_TWO   = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // Upper byte of every zero-page address
   localparam logic [7:0] PAGE_ZERO = 8'h00;

   // Addressing modes
   typedef enum logic [3:0] {
      implied_operand_mode,
      literal_operand_mode,
      direct_address_mode,
      long_address_mode,
      branch_offset_mode,
      bit_modify_mode,
      bit_branch_mode,
      pointer_only_mode,
      pointer_plus_byte_mode,
      pointer_plus_word_mode
   } mode_t;

   // Sequencer states
   typedef enum logic [1:0] {
      st_idle,
      st_wait,
      st_calc
   } state_t;

   // Whole state of the unit
   typedef struct packed {
      state_t      st;
      mode_t       mode;
      logic [1:0]  len;
      logic [1:0]  idx;
      logic        opnd;
      logic [7:0]  opc;
      logic [15:0] pc;
      logic [7:0]  ixr;
      logic        cond;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic        tbit;
      logic [15:0] mem_addr;
      logic        mem_rd;
      logic        busy;
      logic        done;
      logic [15:0] ea;
      logic        ea_valid;
      logic [15:0] next_pc;
      logic        taken;
      logic        carry;
      logic        carry_we;
      logic [2:0]  bit_sel;
      logic        bit_set;
   } core_t;

   // Mode from the opcode's upper nibble; for upper nibble a the lower nibble also counts
   function automatic mode_t mode_of(input logic [7:0] opc);
      case (opc[7:4])
         4'h0: mode_of = bit_branch_mode;
         4'h1: mode_of = bit_modify_mode;
         4'h2: mode_of = branch_offset_mode;
         4'h3, 4'hb: mode_of = direct_address_mode;
         4'h6, 4'he: mode_of = pointer_plus_byte_mode;
         4'h7, 4'hf: mode_of = pointer_only_mode;
         4'ha: mode_of = (opc[3:0] == 4'hd) ? branch_offset_mode : literal_operand_mode;
         4'hc: mode_of = long_address_mode;
         4'hd: mode_of = pointer_plus_word_mode;
         default: mode_of = implied_operand_mode;
      endcase
   endfunction : mode_of

   // Instruction length of a mode
   function automatic logic [1:0] len_of(input mode_t m);
      case (m)
         implied_operand_mode, pointer_only_mode: len_of = LEN_ONE;
         long_address_mode, pointer_plus_word_mode,
         bit_branch_mode: len_of = LEN_THREE;
         default: len_of = LEN_TWO;
      endcase
   endfunction : len_of

   // Unsigned sum with the byte zero-extended to 16 bits
   function automatic logic [15:0] zext_add(input logic [15:0] base,
                                            input logic [7:0] off);
      zext_add = base + {PAGE_ZERO, off};
   endfunction : zext_add

   // Sum with the byte sign-extended to 16 bits
   function automatic logic [15:0] rel_add(input logic [15:0] base,
                                           input logic [7:0] off);
      rel_add = base + {{8{off[7]}}, off};
   endfunction : rel_add
endpackage : ea_pkg

/* ea_mem_model.sv */
`timescale 1ns/10ps
module ea_mem_model (
   input  wire logic        clk,       // Core clock
   input  wire logic        rst_b,     // Reset, active low
   input  wire logic        mem_rd,    // Read strobe
   input  wire logic [15:0] mem_addr,  // Read address
   input  wire logic        slow,      // Answer late when high
   output logic [7:0]       mem_rdata, // Read data
   output logic             mem_valid  // Read data valid
);
   logic [7:0] mem [0:65535];
   logic       pend;
   logic [1:0] cnt;
   logic [7:0] cyc;
   // Late answer three cycles after the strobe cycle; pattern counter runs always
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 1'b0;
         cnt  <= 2'h0;
         cyc  <= 8'h00;
      end else begin
         cyc <= cyc + 8'h01;
         if (slow && mem_rd) begin
            pend <= 1'b1;
            cnt  <= 2'h2;
         end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
         end else begin
            pend <= 1'b0;
         end
      end
   end
   // Prompt answer in the strobe cycle, or late answer
   assign mem_valid = slow ? (pend && cnt == 2'h0) : mem_rd;
   // Outside a read the data lines show a changing pattern
   assign mem_rdata = mem_valid ? mem[mem_addr] : cyc;
endmodule : ea_mem_model

/* addressing_mode_ea_unit_tb_top.sv */
`timescale 1ns/10ps
module addressing_mode_ea_unit_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [15:0] op_pc = 16'h0000;
   logic [7:0] index_val = 8'h00;
   logic cond_ok = 1'b0;
   logic slow = 1'b0;
   logic [7:0] mem_rdata;
   logic mem_valid;
   ea_pkg::mode_t mode;
   logic [15:0] mem_addr, ea, next_pc;
   logic mem_rd, busy, done, ea_valid, taken, carry, carry_we;
   logic [2:0] bit_sel;
   logic bit_set;
   int err_count = 0;
   int num_checks = 0;

   addressing_mode_ea_unit addressing_mode_ea_unit_i (
      .clk(clk), .rst_b(rst_b), .start(start), .opcode(opcode), .op_pc(op_pc),
      .index_val(index_val), .cond_ok(cond_ok), .mem_rdata(mem_rdata),
      .mem_valid(mem_valid), .mode(mode), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .busy(busy), .done(done), .ea(ea), .ea_valid(ea_valid), .next_pc(next_pc),
      .taken(taken), .carry(carry), .carry_we(carry_we), .bit_sel(bit_sel),
      .bit_set(bit_set));
   ea_mem_model ea_mem_model_i (
      .clk(clk), .rst_b(rst_b), .mem_rd(mem_rd), .mem_addr(mem_addr), .slow(slow),
      .mem_rdata(mem_rdata), .mem_valid(mem_valid));

   // Clock at 40 MHz
   always #12.5 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One instruction: place bytes, pulse start, wait for done
   task automatic go(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] ix,
                     input logic c, input logic [7:0] b1, input logic [7:0] b2);
      int n;
      n = 0;
      ea_mem_model_i.mem[pc + 16'h0001] = b1;
      ea_mem_model_i.mem[pc + 16'h0002] = b2;
      @(posedge clk);
      start <= 1'b1;
      opcode <= op;
      op_pc <= pc;
      index_val <= ix;
      cond_ok <= c;
      @(posedge clk);
      start <= 1'b0;
      #1;
      chk(16'(busy), 16'h0001, "busy after start");
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(done), 16'h0001, "done seen");
      chk(16'(busy), 16'h0000, "busy at done");
   endtask : go

   task automatic res(input logic [15:0] pc, input logic [15:0] a, input logic v,
                      input logic t);
      chk(next_pc, pc, "next_pc");
      chk(16'(taken), 16'(t), "taken");
      chk(16'(ea_valid), 16'(v), "ea_valid");
      if (v) chk(ea, a, "ea");
   endtask : res

   task automatic t_implied;
      go(8'h4c, 16'h0100, 8'h33, 1'b0, 8'h00, 8'h00);
      res(16'h0101, 16'h0000, 1'b0, 1'b0);
      chk(16'(mode), 16'(ea_pkg::implied_operand_mode), "mode");
      $display("test implied done");
   endtask : t_implied

   task automatic t_index;
      go(8'hf6, 16'h0200, 8'hff, 1'b0, 8'h00, 8'h00);
      res(16'h0201, 16'h00ff, 1'b1, 1'b0);
      go(8'he6, 16'h0300, 8'hff, 1'b0, 8'hff, 8'h00);
      res(16'h0302, 16'h01fe, 1'b1, 1'b0);
      go(8'hd6, 16'h0400, 8'h01, 1'b0, 8'h12, 8'hff);
      res(16'h0403, 16'h1300, 1'b1, 1'b0);
      go(8'hb6, 16'h0500, 8'h44, 1'b0, 8'h80, 8'h00);
      res(16'h0502, 16'h0080, 1'b1, 1'b0);
      go(8'ha6, 16'h0e00, 8'h00, 1'b0, 8'h55, 8'h00);
      res(16'h0e02, 16'h0e01, 1'b1, 1'b0);
      go(8'hc6, 16'h0f00, 8'h77, 1'b0, 8'h12, 8'h34);
      res(16'h0f03, 16'h1234, 1'b1, 1'b0);
      $display("test indexed done");
   endtask : t_index

   task automatic t_branch;
      go(8'h20, 16'h0600, 8'h00, 1'b1, 8'h80, 8'h00);
      res(16'h0582, 16'h0000, 1'b0, 1'b1);
      go(8'h27, 16'h0700, 8'h00, 1'b1, 8'h7c, 8'h00);
      res(16'h077e, 16'h0000, 1'b0, 1'b1);
      go(8'had, 16'h0800, 8'h00, 1'b0, 8'h7c, 8'h00);
      res(16'h0802, 16'h0000, 1'b0, 1'b0);
      chk(16'(mode), 16'(ea_pkg::branch_offset_mode), "mode");
      $display("test branch done");
   endtask : t_branch

   task automatic t_bitmod;
      go(8'h15, 16'h0900, 8'h00, 1'b0, 8'h3a, 8'h00);
      res(16'h0902, 16'h003a, 1'b1, 1'b0);
      chk(16'({bit_sel, bit_set}), 16'h0004, "clear bit 2");
      go(8'h1e, 16'h0a00, 8'h00, 1'b0, 8'hc0, 8'h00);
      chk(16'({bit_sel, bit_set}), 16'h000f, "set bit 7");
      $display("test bit modify done");
   endtask : t_bitmod

   task automatic t_bitbr;
      ea_mem_model_i.mem[16'h0040] = 8'h80;
      go(8'h0e, 16'h0b00, 8'h00, 1'b0, 8'h40, 8'h7f);
      res(16'h0b82, 16'h0040, 1'b1, 1'b1);
      chk(16'({carry, carry_we}), 16'h0003, "carry");
      slow <= 1'b1;
      ea_mem_model_i.mem[16'h0041] = 8'hfe;
      go(8'h01, 16'h0c00, 8'h00, 1'b1, 8'h41, 8'h80);
      res(16'h0b83, 16'h0041, 1'b1, 1'b1);
      chk(16'({carry, carry_we, bit_sel}), 16'h0008, "carry clear");
      ea_mem_model_i.mem[16'h0042] = 8'h01;
      go(8'h01, 16'h0d00, 8'h00, 1'b0, 8'h42, 8'h80);
      res(16'h0d03, 16'h0042, 1'b1, 1'b0);
      chk(16'({carry, carry_we}), 16'h0003, "carry set");
      slow <= 1'b0;
      $display("test bit branch done");
   endtask : t_bitbr

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_implied();
      t_index();
      t_branch();
      t_bitmod();
      t_bitbr();
      final_report();
   end

   // Watchdog well beyond the expected run of under a hundred cycles
   initial begin
      #50000;
      err_count++;
      final_report();
   end
endmodule : addressing_mode_ea_unit_tb_top
